//--- design/ipc_top.sv
`timescale 1ns/10ps
// How it works
// [R1] Mode 011: source decrements, destination fixed.
// [R2] Mode 100: both pointers stay fixed.
// [R3] Count drops each transfer; zero raises end.
// [R4] Pointers change only after the transfer.
// [R5] Software writes only defined mode codes.
// [R6] Twenty-six slots, 24 used as channels, each flag plus priority.
// [R7] Flags clear on reset, accept, writes, DMA.
// [R8] Level codes 1 to 6 set priority.
// [R9] Level 0 or 7 never requests; the code still starts DMA for a start-vector source at these levels.
// [R10] Pin and watchdog non-maskable run at 7.
// [R11] Equal levels: lowest vector wins.
// [R12] Bits 3 and 7 show flags.
// [R13] Highest pending request presented with vector.
// [R14] Accept only above current mask level.
// [R15] Accept sets mask to level plus one.
// [R16] Return restores mask saved at entry.
// [R17] Four start vectors divert sources to DMA.
// [R18] Software loads parameters before start vector.
// [R19] Vector written to clear register clears flag.
// [R20] Edge to level switch clears flag.
// [R21] Software clears port functions before mode change.
// [R22] Level bit and polarity bit choose detection.
// [R23] Non-maskable pin: falling, or both edges.
// [R24] Counter mode only counts, five states.
module ipc_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  input wire logic [25:0] periph_req,
  input wire logic [5:0] ext_pin,
  input wire logic nmi_pin,
  input wire logic wdt_req,
  input wire logic cpu_take,
  input wire logic cpu_return_from_interrupt_instr,
  output logic int_pending,
  output logic [2:0] int_level,
  output logic [5:0] int_vector,
  output logic int_taken,
  output logic [2:0] cpu_mask_level,
  output logic mem_rd,
  output logic mem_wr,
  output logic [23:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic [31:0] mem_rdata
);

  logic [2:0] lvl_q [ipc_pkg::NCH];
  logic [25:0] flag_q;
  logic [25:0] flag_d;
  logic [25:0] eff;
  logic [25:0] elig;
  logic [25:0] ev;
  logic [25:0] le_clr;
  logic [25:0] dma_own;
  logic [7:0] mode_a_q;
  logic [7:0] mode_b_q;
  logic [5:0] pin_q;
  logic [5:0] le_q;
  logic nmi_q;
  logic nmi_flag_q;
  logic wdt_flag_q;
  logic [5:0] sv_q [ipc_pkg::NDMA];
  logic [23:0] src_q [ipc_pkg::NDMA];
  logic [23:0] dst_q [ipc_pkg::NDMA];
  logic [15:0] cnt_q [ipc_pkg::NDMA];
  logic [4:0] dmode_q [ipc_pkg::NDMA];
  logic [2:0] stk_q [ipc_pkg::STK];
  logic [2:0] sp_q;
  logic dma_busy_q;
  logic start_q;
  logic [1:0] dch_q;

  ipc_dma_if dif ();

  ipc_udma u_dma (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(dif.eng),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_size(mem_size),
    .mem_rdata(mem_rdata)
  );

  // Register decode.
  wire mode_a_wr = wr_stb && addr == ipc_pkg::OFS_MODE_A;
  wire mode_b_wr = wr_stb && addr == ipc_pkg::OFS_MODE_B;
  wire mask_wr = wr_stb && addr == ipc_pkg::OFS_MASK;
  wire clr_wr = wr_stb && addr == ipc_pkg::OFS_CLR;
  wire sv_hit = addr[7:2] == ipc_pkg::OFS_DMAV[7:2];
  wire dp_hit = addr[7:4] == ipc_pkg::OFS_DPAR[7:4];
  wire [1:0] dp_ch = addr[3:2];
  wire [5:0] clr_idx = wr_data[5:0] - ipc_pkg::VEC_BASE;
  wire clr_ok = clr_wr && clr_idx < 6'h1A;
  wire [25:0] sw_clr = clr_ok ? 26'h1 << clr_idx : 26'h0; // see [R19]

  // External pins; configuration pairs are {polarity, level select}.
  wire [11:0] pin_cfg = {mode_b_q[6:1], mode_a_q[6:1]};
  logic [5:0] pin_le;
  logic [5:0] pin_pol;
  logic [5:0] pin_ev;
  logic [5:0] pin_lvl;
  for (genvar p = 0; p < ipc_pkg::NPIN; p++) begin : g_pin
    assign pin_le[p] = pin_cfg[2*p]; // see [R22]
    assign pin_pol[p] = pin_cfg[2*p+1]; // see [R22]
    assign pin_ev[p] = !pin_le[p] && (pin_pol[p] ? (pin_q[p] && !ext_pin[p]) : (!pin_q[p] && ext_pin[p])); // see [R22]
    assign pin_lvl[p] = ext_pin[p] ^ pin_pol[p]; // see [R20]
  end

  // End-of-transfer events land on the transfer-end sources.
  wire [25:0] tc_ev = (dif.done && dif.tc_end) ? 26'(26'h1 << (ipc_pkg::TC_SLOT + int'(dch_q))) : 26'h0; // see [R3]

  // Accept logic, declared ahead of the flags it clears.
  logic [25:0] take_clr;
  logic [25:0] dma_clr;

  for (genvar s = 0; s < ipc_pkg::NCH; s++) begin : g_slot
    if (s == 0 || (s >= 2 && s <= 6)) begin : g_ext
      localparam int P = (s == 0) ? 0 : s - 1;
      assign ev[s] = pin_ev[P];
      // Level mode bypasses the flag; the pin itself is the request.
      assign eff[s] = pin_le[P] ? pin_lvl[P] : flag_q[s]; // see [R20]
      assign le_clr[s] = pin_le[P] && !le_q[P]; // see [R20]
    end else begin : g_int
      assign ev[s] = periph_req[s] || tc_ev[s];
      assign eff[s] = flag_q[s];
      assign le_clr[s] = 1'b0;
    end
    // A new event wins over any clear arriving in the same cycle.
    assign flag_d[s] = ipc_pkg::SLOT_USED[s] &&
                       (ev[s] || (flag_q[s] && !(take_clr[s] || dma_clr[s] || sw_clr[s] || le_clr[s]))); // see [R6] [R7]
    assign elig[s] = eff[s] && ipc_pkg::SLOT_USED[s] && !dma_own[s] &&
                     lvl_q[s] != ipc_pkg::LVL_OFF && lvl_q[s] != ipc_pkg::LVL_TOP; // see [R8] [R9]
  end

  // Start-vector matching; the lowest channel wins a shared vector.
  logic [5:0] sv_slot [ipc_pkg::NDMA];
  logic [3:0] sv_ok;
  logic [3:0] dma_hit;
  for (genvar k = 0; k < ipc_pkg::NDMA; k++) begin : g_sv
    assign sv_slot[k] = sv_q[k] - ipc_pkg::VEC_BASE;
    assign sv_ok[k] = sv_q[k] != 6'h00 && sv_slot[k] < 6'h1A; // see [R17]
    assign dma_hit[k] = sv_ok[k] && eff[sv_slot[k][4:0]]; // see [R17]
  end

  logic [1:0] dma_pick;
  always_comb begin
    dma_own = 26'h0;
    dma_pick = 2'h0;
    for (int k = ipc_pkg::NDMA - 1; k >= 0; k--) begin
      if (sv_ok[k]) dma_own = dma_own | (26'h1 << sv_slot[k]);
      if (dma_hit[k]) dma_pick = 2'(k);
    end
  end

  // Highest level wins; scanning downward leaves the lowest vector on a tie.
  logic [4:0] best;
  logic [2:0] best_lvl;
  logic best_ok;
  always_comb begin
    best = 5'h0;
    best_lvl = 3'h0;
    best_ok = 1'b0;
    for (int s = ipc_pkg::NCH - 1; s >= 0; s--) begin
      if (elig[s] && lvl_q[s] >= best_lvl) begin // see [R11] [R13]
        best = 5'(s);
        best_lvl = lvl_q[s];
        best_ok = 1'b1;
      end
    end
  end

  // Non-maskable sources always sit at the top level.
  wire nmi_rise = !nmi_q && nmi_pin;
  wire nmi_fall = nmi_q && !nmi_pin;
  wire nmi_ev = nmi_fall || (mode_a_q[ipc_pkg::NMI_BOTH_BIT] && nmi_rise); // see [R23]
  wire go_nmi = nmi_flag_q; // see [R10]
  wire go_wdt = wdt_flag_q && !nmi_flag_q; // see [R10]
  wire go_dma = !nmi_flag_q && !wdt_flag_q && |dma_hit && !dma_busy_q && cpu_mask_level != ipc_pkg::LVL_TOP;
  wire go_int = !nmi_flag_q && !wdt_flag_q && !go_dma && best_ok && best_lvl > cpu_mask_level; // see [R14]
  wire pres = go_nmi || go_wdt || go_dma || go_int;
  wire take = cpu_take && pres;
  wire take_int = take && !go_dma;
  wire [2:0] pres_lvl = (go_nmi || go_wdt) ? ipc_pkg::LVL_TOP : go_dma ? ipc_pkg::LVL_DMA : best_lvl;
  wire [5:0] pres_vec = go_nmi ? ipc_pkg::NMI_VEC : go_wdt ? ipc_pkg::WDT_VEC :
                        go_dma ? sv_q[dma_pick] : ipc_pkg::VEC_BASE + 6'(best);
  // Mask goes one above the taken level; the top level cannot go higher.
  wire [2:0] mask_new = (pres_lvl == ipc_pkg::LVL_TOP) ? ipc_pkg::LVL_TOP : pres_lvl + 3'h1; // see [R15]
  wire [2:0] sp_dn = sp_q - 3'h1;

  assign take_clr = (take && go_int) ? 26'h1 << best : 26'h0; // see [R7]
  assign dma_clr = (take && go_dma) ? 26'h1 << sv_slot[dma_pick] : 26'h0; // see [R7]

  // Engine hook-up.
  assign dif.start = start_q;
  assign dif.ch = dch_q;
  assign dif.mode = dmode_q[dch_q][4:2];
  assign dif.size = dmode_q[dch_q][1:0];
  assign dif.src = src_q[dch_q];
  assign dif.dst = dst_q[dch_q];
  assign dif.cnt = cnt_q[dch_q];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_q <= 26'h0; // see [R7]
      mode_a_q <= ipc_pkg::RST_8;
      mode_b_q <= ipc_pkg::RST_8;
      pin_q <= 6'h0;
      le_q <= 6'h0;
      nmi_q <= 1'b1;
    end else begin
      flag_q <= flag_d;
      if (mode_a_wr) mode_a_q <= wr_data[7:0];
      if (mode_b_wr) mode_b_q <= wr_data[7:0];
      pin_q <= ext_pin;
      le_q <= pin_le;
      nmi_q <= nmi_pin;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nmi_flag_q <= 1'b0;
      wdt_flag_q <= 1'b0;
    end else begin
      nmi_flag_q <= nmi_ev || (nmi_flag_q && !(take && go_nmi));
      wdt_flag_q <= wdt_req || (wdt_flag_q && !(take && go_wdt));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int s = 0; s < ipc_pkg::NCH; s++) lvl_q[s] <= 3'h0;
    end else begin
      for (int s = 0; s < ipc_pkg::NCH; s++) begin
        if (wr_stb && addr == ipc_pkg::PRIO_OFS[s/2])
          lvl_q[s] <= wr_data[(s%2)*ipc_pkg::HALF_POS +: 3]; // see [R6] [R8]
      end
    end
  end

  // Mask level with a save stack for nested entries.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cpu_mask_level <= ipc_pkg::LVL_TOP;
      sp_q <= 3'h0;
      for (int i = 0; i < ipc_pkg::STK; i++) stk_q[i] <= 3'h0;
    end else if (take_int) begin
      stk_q[sp_q] <= cpu_mask_level;
      sp_q <= sp_q + 3'h1;
      cpu_mask_level <= mask_new; // see [R15]
    end else if (cpu_return_from_interrupt_instr) begin
      sp_q <= sp_dn;
      cpu_mask_level <= stk_q[sp_dn]; // see [R16]
    end else if (mask_wr) begin
      cpu_mask_level <= wr_data[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      int_pending <= 1'b0;
      int_level <= 3'h0;
      int_vector <= 6'h0;
      int_taken <= 1'b0;
    end else begin
      int_pending <= pres; // see [R13]
      int_level <= pres_lvl;
      int_vector <= pres_vec; // see [R13]
      int_taken <= take_int;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dma_busy_q <= 1'b0;
      start_q <= 1'b0;
      dch_q <= 2'h0;
    end else begin
      start_q <= take && go_dma; // see [R17]
      if (take && go_dma) dch_q <= dma_pick;
      if (take && go_dma) dma_busy_q <= 1'b1;
      else if (dif.done) dma_busy_q <= 1'b0;
    end
  end

  // Channel parameters; engine write-back wins over a colliding software write.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int k = 0; k < ipc_pkg::NDMA; k++) begin
        sv_q[k] <= 6'h0;
        src_q[k] <= 24'h0;
        dst_q[k] <= 24'h0;
        cnt_q[k] <= 16'h0;
        dmode_q[k] <= 5'h0;
      end
    end else begin
      if (wr_stb && sv_hit) sv_q[addr[1:0]] <= wr_data[5:0]; // see [R17]
      if (wr_stb && dp_hit) begin
        case (addr[1:0])
          2'h0: src_q[dp_ch] <= wr_data[23:0];
          2'h1: dst_q[dp_ch] <= wr_data[23:0];
          2'h2: cnt_q[dp_ch] <= wr_data[15:0];
          default: dmode_q[dp_ch] <= wr_data[4:0]; // see [R5]
        endcase
      end
      if (dif.done) begin
        src_q[dch_q] <= dif.new_src; // see [R4]
        dst_q[dch_q] <= dif.new_dst;
        cnt_q[dch_q] <= dif.new_cnt; // see [R3]
        if (dif.tc_end) sv_q[dch_q] <= 6'h0;
      end
    end
  end

  // Read mux; write-only and unmapped addresses read zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    for (int r = 0; r < ipc_pkg::NPRIO; r++) begin
      if (addr == ipc_pkg::PRIO_OFS[r]) begin
        rd_mux[2:0] = lvl_q[2*r] & {3{ipc_pkg::SLOT_USED[2*r]}};
        rd_mux[ipc_pkg::FLAG_POS] = eff[2*r] && ipc_pkg::SLOT_USED[2*r]; // see [R12]
        rd_mux[6:4] = lvl_q[2*r+1] & {3{ipc_pkg::SLOT_USED[2*r+1]}};
        rd_mux[ipc_pkg::FLAG_POS+ipc_pkg::HALF_POS] = eff[2*r+1] && ipc_pkg::SLOT_USED[2*r+1]; // see [R12]
      end
    end
    if (sv_hit) rd_mux = {26'h0, sv_q[addr[1:0]]};
    if (addr == ipc_pkg::OFS_MASK) rd_mux = {29'h0, cpu_mask_level};
    if (dp_hit) begin
      case (addr[1:0])
        2'h0: rd_mux = {8'h0, src_q[dp_ch]};
        2'h1: rd_mux = {8'h0, dst_q[dp_ch]};
        2'h2: rd_mux = {16'h0, cnt_q[dp_ch]};
        default: rd_mux = {27'h0, dmode_q[dp_ch]};
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) rd_data <= 32'h0;
    else rd_data <= rd_stb ? rd_mux : 32'h0;
  end

endmodule : ipc_top

//--- design/ipc_pkg.sv
package ipc_pkg;
  localparam int NCH = 26;
  localparam int NDMA = 4;
  localparam int NPRIO = 13;
  localparam int NPIN = 6;
  localparam int TC_SLOT = 22;
  localparam int STK = 8;
  localparam logic [7:0] OFS_DMAV = 8'h80;
  localparam logic [7:0] OFS_MASK = 8'h84;
  localparam logic [7:0] OFS_CLR = 8'h88;
  localparam logic [7:0] OFS_MODE_A = 8'h8C;
  localparam logic [7:0] OFS_MODE_B = 8'h8D;
  localparam logic [7:0] OFS_DPAR = 8'hC0;
  localparam logic [7:0] PRIO_OFS [NPRIO] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97,
                                             8'h99, 8'h9B, 8'h9C, 8'h9D, 8'hA0, 8'hA1};
  localparam logic [25:0] SLOT_USED = 26'h3FDFF7F;
  localparam logic [5:0] VEC_BASE = 6'h0A;
  localparam logic [5:0] NMI_VEC = 6'h02;
  localparam logic [5:0] WDT_VEC = 6'h03;
  localparam logic [2:0] LVL_DMA = 3'h6;
  localparam logic [2:0] LVL_TOP = 3'h7;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam int FLAG_POS = 3;
  localparam int HALF_POS = 4;
  localparam int MODE_POS = 2;
  localparam int NMI_BOTH_BIT = 0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [3:0] ST_BYTE = 4'h8;
  localparam logic [3:0] ST_WORD = 4'hC;
  localparam logic [3:0] ST_COUNT = 4'h5;
  localparam logic [7:0] RST_8 = 8'h00;
  typedef enum logic [2:0] {
    IPC_DST_INC,
    IPC_DST_DEC,
    IPC_SRC_INC,
    IPC_SRC_DEC,
    IPC_FIXED,
    IPC_COUNT
  } ipc_mode_e;
endpackage : ipc_pkg

//--- design/ipc_dma_if.sv
`timescale 1ns/10ps
interface ipc_dma_if;
  logic start;
  logic [1:0] ch;
  logic [2:0] mode;
  logic [1:0] size;
  logic [23:0] src;
  logic [23:0] dst;
  logic [15:0] cnt;
  logic done;
  logic tc_end;
  logic [23:0] new_src;
  logic [23:0] new_dst;
  logic [15:0] new_cnt;
  modport ctl (output start, ch, mode, size, src, dst, cnt, input done, tc_end, new_src, new_dst, new_cnt);
  modport eng (input start, ch, mode, size, src, dst, cnt, output done, tc_end, new_src, new_dst, new_cnt);
endinterface : ipc_dma_if

//--- design/ipc_udma.sv
`timescale 1ns/10ps
module ipc_udma (
  input wire logic clock,
  input wire logic sys_rst,
  ipc_dma_if.eng d,
  output logic mem_rd,
  output logic mem_wr,
  output logic [23:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic [31:0] mem_rdata
);
  typedef enum logic [1:0] {E_IDLE, E_RD, E_WR, E_WAIT} ipc_eng_e;
  ipc_eng_e st_q;
  logic [3:0] cyc_q;
  logic [2:0] mode_q;
  logic [23:0] src_q, dst_q;
  logic [15:0] cnt_q;
  wire [23:0] step = (mem_size == ipc_pkg::SZ_BYTE) ? 24'h1 : (mem_size == ipc_pkg::SZ_WORD) ? 24'h2 : 24'h4;
  wire is_cnt = (mode_q == ipc_pkg::IPC_COUNT);
  wire [3:0] need = is_cnt ? ipc_pkg::ST_COUNT : (mem_size == ipc_pkg::SZ_BYTE) ? ipc_pkg::ST_BYTE : ipc_pkg::ST_WORD;
  wire [15:0] cnt_dec = cnt_q - 16'h1; // see [R3]
  // Pointers move only after the access, so each transfer uses the old value.
  wire [23:0] src_nx = (mode_q == ipc_pkg::IPC_SRC_INC) ? src_q + step : // see [R4]
                       (mode_q == ipc_pkg::IPC_SRC_DEC) ? src_q - step : src_q; // see [R1] [R2]
  wire [23:0] dst_nx = (mode_q == ipc_pkg::IPC_DST_INC) ? dst_q + step :
                       (mode_q == ipc_pkg::IPC_DST_DEC) ? dst_q - step : dst_q; // see [R1] [R2]
  wire fin = (st_q == E_WAIT) && (cyc_q >= need - 4'h1); // see [R1] [R24]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= E_IDLE;
      cyc_q <= 4'h0;
    end else begin
      cyc_q <= (st_q == E_IDLE) ? 4'h1 : cyc_q + 4'h1;
      case (st_q)
        E_IDLE: if (d.start) st_q <= (d.mode == ipc_pkg::IPC_COUNT) ? E_WAIT : E_RD; // see [R24]
        E_RD: st_q <= E_WR;
        E_WR: st_q <= E_WAIT;
        E_WAIT: if (fin) st_q <= E_IDLE;
        default: st_q <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= 3'h0;
      src_q <= 24'h0;
      dst_q <= 24'h0;
      cnt_q <= 16'h0;
      mem_size <= 2'h0;
    end else if (st_q == E_IDLE && d.start) begin
      mode_q <= d.mode;
      src_q <= d.src;
      dst_q <= d.dst;
      cnt_q <= d.cnt;
      mem_size <= d.size;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 24'h0;
      mem_wdata <= 32'h0;
    end else begin
      mem_rd <= (st_q == E_IDLE) && d.start && (d.mode != ipc_pkg::IPC_COUNT);
      mem_wr <= (st_q == E_WR);
      if (st_q == E_IDLE) mem_addr <= d.src;
      if (st_q == E_WR) mem_addr <= dst_q;
      if (st_q == E_WR) mem_wdata <= mem_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      d.done <= 1'b0;
      d.tc_end <= 1'b0;
      d.new_src <= 24'h0;
      d.new_dst <= 24'h0;
      d.new_cnt <= 16'h0;
    end else begin
      d.done <= fin;
      d.tc_end <= fin && (cnt_dec == 16'h0); // see [R3] [R24]
      d.new_src <= is_cnt ? src_q : src_nx;
      d.new_dst <= is_cnt ? dst_q : dst_nx;
      d.new_cnt <= cnt_dec;
    end
  end
endmodule : ipc_udma

//--- sim/ipc_top_asserts.sv
`timescale 1ns/10ps
module ipc_top_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rd_data,
  input wire logic wdt_req,
  input wire logic cpu_take,
  input wire logic cpu_return_from_interrupt_instr,
  input wire logic int_pending,
  input wire logic [2:0] int_level,
  input wire logic int_taken,
  input wire logic [2:0] cpu_mask_level,
  input wire logic mem_rd,
  input wire logic mem_wr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence eng_read_s;
    mem_rd;
  endsequence
  sequence eng_write_s;
    ##2 mem_wr;
  endsequence
  rd_idle_zero_a: assert property (!$past(rd_stb) |-> rd_data == 32'h0)
    else $error("read data outside answer cycle");
  take_cause_a: assert property (int_taken |-> $past(cpu_take))
    else $error("acceptance without cpu take");
  mask_raise_a: assert property (int_taken && $past(int_level) != 3'h7
    |-> cpu_mask_level == $past(int_level) + 3'h1)
    else $error("mask not level plus one");
  above_mask_a: assert property (int_taken
    |-> ($past(int_level) == 3'h7 || $past(int_level) > $past(cpu_mask_level)))
    else $error("accepted at or below mask");
  dead_level_a: assert property (int_pending |-> int_level != 3'h0)
    else $error("level zero presented");
  wdt_top_a: assert property (wdt_req && !cpu_take |-> ##[1:3] (int_pending && int_level == 3'h7))
    else $error("watchdog not presented at level seven");
  mask_cause_a: assert property ($changed(cpu_mask_level) |-> $past(cpu_take || cpu_return_from_interrupt_instr || wr_stb))
    else $error("mask changed without cause");
  dma_order_a: assert property (eng_read_s |-> eng_write_s)
    else $error("engine write not two cycles after read");
  wr_single_a: assert property (mem_wr |=> !mem_wr)
    else $error("engine write longer than one cycle");
endmodule : ipc_top_asserts
bind ipc_top ipc_top_asserts chk_u (.clock(clock), .sys_rst(sys_rst), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .wdt_req(wdt_req), .cpu_take(cpu_take), .cpu_return_from_interrupt_instr(cpu_return_from_interrupt_instr), .int_pending(int_pending),
  .int_level(int_level), .int_taken(int_taken), .cpu_mask_level(cpu_mask_level), .mem_rd(mem_rd), .mem_wr(mem_wr));

//--- sim/ipc_mem_model.sv
`timescale 1ns/10ps
module ipc_mem_model (
  input wire logic clock,
  input wire logic mem_rd,
  output logic [31:0] mem_rdata,
  output logic [31:0] last_rd
);
  logic [31:0] nxt;
  initial begin
    mem_rdata = 32'h0;
    last_rd = 32'h0;
  end
  // Data stand only in the cycle after a read; the bus flips otherwise so stale data cannot pass.
  always @(posedge clock) begin
    nxt = $urandom;
    if (mem_rd) begin
      last_rd <= nxt;
      mem_rdata <= nxt;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : ipc_mem_model

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [25:0] periph_req = 26'h0;
  logic [5:0] ext_pin = 6'h00;
  logic nmi_pin = 1'b1;
  logic wdt_req = 1'b0;
  logic cpu_take = 1'b0;
  logic cpu_return_from_interrupt_instr = 1'b0;
  logic [31:0] rd_data, mem_wdata, mem_rdata, last_rd;
  logic int_pending, int_taken, mem_rd, mem_wr;
  logic rd_v = 1'b0;
  logic [2:0] int_level, cpu_mask_level;
  logic [5:0] int_vector;
  logic [23:0] mem_addr;
  logic [1:0] mem_size;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int i;
  always #5 clock = ~clock;
  ipc_top dut_u (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .periph_req(periph_req), .ext_pin(ext_pin), .nmi_pin(nmi_pin),
    .wdt_req(wdt_req), .cpu_take(cpu_take), .cpu_return_from_interrupt_instr(cpu_return_from_interrupt_instr), .int_pending(int_pending),
    .int_level(int_level), .int_vector(int_vector), .int_taken(int_taken), .cpu_mask_level(cpu_mask_level),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .mem_rdata(mem_rdata));
  ipc_mem_model mem_u (.clock(clock), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .last_rd(last_rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read answers are compared one cycle after the strobe was taken.
  always @(negedge clock) begin
    if (rd_v) begin
      chk(rd_data, exp_q.pop_front());
    end
    rd_v = rd_stb;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clock);
  endtask : rd
  task automatic idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic raise(input logic [25:0] m);
    idle(1);
    periph_req <= m;
    @(posedge clock);
    periph_req <= 26'h0;
    @(posedge clock);
  endtask : raise
  task automatic take_chk(input logic t, input logic [2:0] m, input logic [2:0] l, input logic [5:0] v,
                          input logic p);
    cpu_take <= 1'b1;
    @(negedge clock);
    if (p) begin
      chk(int_pending, 1'b1);
      chk(int_level, l);
      chk(int_vector, v);
    end
    @(posedge clock);
    cpu_take <= 1'b0;
    @(negedge clock);
    chk(int_taken, t);
    chk(cpu_mask_level, m);
    @(posedge clock);
  endtask : take_chk
  task automatic pin_ev(input logic v, input logic t);
    nmi_pin <= v;
    idle(3);
    take_chk(t, 3'h7, 3'h7, 6'h02, t);
  endtask : pin_ev
  task automatic mem_ev(input logic w, input logic [23:0] a);
    int j;
    j = 0;
    @(negedge clock);
    while ((w ? mem_wr : mem_rd) !== 1'b1 && j < 20) begin
      @(negedge clock);
      j++;
    end
    chk(j < 20, 1'b1);
    chk(mem_addr, a);
    chk(mem_size, ipc_pkg::SZ_BYTE);
    if (w) begin
      chk(mem_wdata[7:0], last_rd[7:0]);
    end
    @(posedge clock);
  endtask : mem_ev
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  initial begin
    #100us;
    err_count++;
    $display("unexpected at %0t: timeout", $time);
    results();
  end
  initial begin
    void'($urandom(32'h8987));
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < ipc_pkg::NPRIO; i++) rd(ipc_pkg::PRIO_OFS[i], 32'h0);
    rd(ipc_pkg::OFS_MASK, 32'h7);
    rd(ipc_pkg::OFS_MODE_A, 32'h0);
    rd(8'hFF, 32'h0);
    wr(8'h97, 32'h61);
    rd(8'h97, 32'h61);
    idle(2);
    $display("reset and register test done");
    wr(ipc_pkg::OFS_MASK, 32'h0);
    wr(8'h95, 32'h23);
    raise(26'h100);
    take_chk(1'b1, 3'h4, 3'h3, 6'h12, 1'b1);
    rd(8'h95, 32'h23);
    raise(26'h200);
    take_chk(1'b0, 3'h4, 3'h2, 6'h13, 1'b0);
    rd(8'h95, 32'hA3);
    cpu_return_from_interrupt_instr <= 1'b1;
    idle(1);
    cpu_return_from_interrupt_instr <= 1'b0;
    idle(2);
    take_chk(1'b1, 3'h3, 3'h2, 6'h13, 1'b1);
    $display("acceptance test done");
    wr(8'h95, 32'h55);
    raise(26'h300);
    take_chk(1'b1, 3'h6, 3'h5, 6'h12, 1'b1);
    wr(ipc_pkg::OFS_CLR, 32'h13);
    rd(8'h95, 32'h55);
    wr(8'h95, 32'h70);
    raise(26'h300);
    idle(2);
    @(negedge clock);
    chk(int_pending, 1'b0);
    @(posedge clock);
    wr(ipc_pkg::OFS_CLR, 32'h12);
    wr(ipc_pkg::OFS_CLR, 32'h13);
    $display("level test done");
    wr(ipc_pkg::OFS_MASK, 32'h7);
    idle(1);
    wdt_req <= 1'b1;
    @(posedge clock);
    wdt_req <= 1'b0;
    @(posedge clock);
    take_chk(1'b1, 3'h7, 3'h7, 6'h03, 1'b1);
    pin_ev(1'b0, 1'b1);
    pin_ev(1'b1, 1'b0);
    wr(ipc_pkg::OFS_MODE_A, 32'h1);
    pin_ev(1'b0, 1'b1);
    pin_ev(1'b1, 1'b1);
    $display("non-maskable test done");
    wr(ipc_pkg::OFS_MODE_A, 32'h0);
    ext_pin <= 6'h01;
    idle(3);
    rd(8'h90, 32'h08);
    wr(ipc_pkg::OFS_CLR, 32'h0A);
    rd(8'h90, 32'h00);
    wr(ipc_pkg::OFS_MODE_A, 32'h4);
    ext_pin <= 6'h00;
    idle(3);
    rd(8'h90, 32'h08);
    wr(ipc_pkg::OFS_MODE_A, 32'h2);
    idle(2);
    rd(8'h90, 32'h00);
    wr(ipc_pkg::OFS_MODE_A, 32'h6);
    idle(2);
    rd(8'h90, 32'h08);
    // Back in edge mode the flag left by the falling edge must be gone.
    wr(ipc_pkg::OFS_MODE_A, 32'h0);
    rd(8'h90, 32'h00);
    wr(ipc_pkg::OFS_MODE_B, 32'h2);
    ext_pin <= 6'h08;
    idle(2);
    rd(8'h92, 32'h08);
    $display("external pin test done");
    wr(ipc_pkg::OFS_MASK, 32'h0);
    wr(8'h95, 32'h0);
    for (i = 0; i < 6; i++) begin
      wr(ipc_pkg::OFS_DPAR, 32'h100);
      wr(ipc_pkg::OFS_DPAR + 8'h01, 32'h200);
      wr(ipc_pkg::OFS_DPAR + 8'h02, 32'h1);
      wr(ipc_pkg::OFS_DPAR + 8'h03, i << 2);
      wr(ipc_pkg::OFS_DMAV, 32'h12);
      raise(26'h100);
      take_chk(1'b0, 3'h0, ipc_pkg::LVL_DMA, 6'h12, 1'b1);
      if (i < 5) begin
        mem_ev(1'b0, 24'h100);
        mem_ev(1'b1, 24'h200);
      end
      idle(16);
      rd(ipc_pkg::OFS_DPAR, 32'h100 + (i == 2) - (i == 3));
      rd(ipc_pkg::OFS_DPAR + 8'h01, 32'h200 + (i == 0) - (i == 1));
      rd(ipc_pkg::OFS_DPAR + 8'h02, 32'h0);
      rd(ipc_pkg::OFS_DMAV, 32'h0);
      rd(8'hA0, 32'h08);
      wr(ipc_pkg::OFS_CLR, 32'h20);
      idle(1);
    end
    idle(3);
    $display("transfer test done");
    results();
  end
endmodule : tb
